//--- logic/fsfwc_top.sv
// fault status word codec: condition encoding, request detect, axi4-lite regs
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Operation
// - each update goes out as seven status bits then one parity bit.
// - parity makes the total count of ones in eight bits odd.
// - word holds four independent fields so faults of different fields combine.
// - all-zero ready word is sent once power-up completes.
// - a status request with no fault present is answered with the zero word.
// - bits 0-2 code overvoltage, four undervoltage levels, thermal, low-side unready.
// - bits 3-4 code thermal warning, thermal shutdown, high-side unready.
// - low-side unready on config pin fault, sense short, or trim corruption.
// - high-side unready on link loss, bypass or rail range, config pin fault.
// - both ends only pull the shared line low; a pull-up makes high.
module fsfwc_top import fsfwc_pkg::*; #(
    parameter int BIT_CYCLES = BIT_CYC,
    parameter int REQ_CYCLES = REQ_CYC
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic bus_overvoltage, // dc bus above limit
    input wire logic bus_undervoltage, // dc bus below a limit
    input wire logic [1:0] uv_level, // 0:100% 1:85% 2:70% 3:55%
    input wire logic system_thermal, // system thermal fault
    input wire logic low_side_config_fault, // low_side_config_pin open/short
    input wire logic sense_config_short, // sense pin shorted to config pin
    input wire logic trim_corrupt, // trim bits corrupted
    input wire logic ls_thermal_warn, // low-side switch hot
    input wire logic ls_thermal_shutdown, // low-side switch shut down
    input wire logic hs_link_loss, // high-to-low internal link lost
    input wire logic high_side_bypass_supply_bad, // bypass rail out of range
    input wire logic hs_rail_bad, // internal 5 v rail out of range
    input wire logic high_side_config_fault, // high_side_config_pin open/short
    input wire logic ls_overcurrent, // low-side overcurrent
    input wire logic hs_overcurrent, // high-side overcurrent
    input wire logic fault_bus_i, // sensed line level
    output logic fault_bus_o, // line drive value, always low
    output logic fault_bus_oe, // high while pulling low
    output logic irq // unmasked status pending
);
    // condition encoding
    logic low_side_driver_unready, high_side_driver_unready;
    logic [2:0] field1;
    logic [1:0] field2;
    logic [WORD_W-1:0] next_word, cur_word, last_word;
    assign low_side_driver_unready = low_side_config_fault | sense_config_short
        | trim_corrupt;
    assign high_side_driver_unready = hs_link_loss | high_side_bypass_supply_bad
        | hs_rail_bad | high_side_config_fault;
    // one code per field, worst condition wins where two could overlap
    assign field1 = low_side_driver_unready ? F1_LS_UNREADY :
        system_thermal ? F1_SYS_THERM :
        bus_overvoltage ? F1_OV :
        !bus_undervoltage ? F1_NONE :
        (uv_level == UV_100) ? F1_UV100 :
        (uv_level == UV_85) ? F1_UV85 :
        (uv_level == UV_70) ? F1_UV70 : F1_UV55;
    assign field2 = high_side_driver_unready ? F2_HS_UNREADY :
        ls_thermal_shutdown ? F2_SHUT :
        ls_thermal_warn ? F2_WARN : F2_NONE;
    assign next_word = {hs_overcurrent, ls_overcurrent, field2, field1};

    // request detection, line held low long enough while we are silent
    logic tx_busy, tx_oe, tx_done, tx_bus_o;
    logic [15:0] low_cnt;
    logic req_seen, powerup_pend, send_pend, tx_en, launch_q;
    localparam logic [15:0] REQ_END = 16'(REQ_CYCLES - 1);
    wire line_low = !fault_bus_i && !tx_busy && !launch_q;
    wire req_hit = line_low && (low_cnt == REQ_END);
    wire req_launch = req_seen && fault_bus_i;
    wire changed = (cur_word != last_word);
    wire launch = tx_en && !tx_busy && !launch_q
        && (powerup_pend || req_launch || send_pend || changed);
    // power-up frame carries the ready word, later ones the live word
    wire [WORD_W-1:0] launch_word = powerup_pend ? READY_WORD : cur_word;
    wire [FRAME_W-1:0] launch_frame = {fsfwc_parity(launch_word), launch_word};

    always_ff @(posedge aclk) begin
        if (!aresetn) low_cnt <= 16'h0000;
        else if (!line_low) low_cnt <= 16'h0000;
        else if (!req_hit) low_cnt <= low_cnt + 16'h0001;
    end

    // pending sends; a new cause in the launch cycle is kept
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_seen <= 1'b0;
            powerup_pend <= 1'b1;
            launch_q <= 1'b0;
            cur_word <= READY_WORD;
            last_word <= READY_WORD;
        end else begin
            req_seen <= req_hit || (req_seen && !(launch && !powerup_pend));
            powerup_pend <= powerup_pend && !launch;
            launch_q <= launch;
            cur_word <= next_word;
            if (launch) last_word <= launch_word;
        end
    end

    fsfwc_tx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_tx (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(launch),
        .frame(launch_frame),
        .busy(tx_busy),
        .bus_o(tx_bus_o),
        .bus_oe(tx_oe),
        .done(tx_done)
    );
    assign fault_bus_o = tx_bus_o;
    assign fault_bus_oe = tx_oe;

    // axi4-lite write channel, address and data taken in either order
    logic aw_got, w_got;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    always_ff @(posedge aclk) begin
        if (!aresetn || (s_axi_bvalid && s_axi_bready)) begin
            aw_got <= 1'b0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            s_axi_awready <= 1'b0;
            waddr <= s_axi_awaddr;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || (s_axi_bvalid && s_axi_bready)) begin
            w_got <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata <= s_axi_wdata;
            wstrb <= s_axi_wstrb;
        end
    end

    // write decode on the aligned word address
    wire [ADDR_W-1:0] wa = {waddr[ADDR_W-1:2], 2'b00};
    wire wr_fire = aw_got && w_got && !s_axi_bvalid;
    wire w_ctrl = (wa == OFF_CTRL);
    wire w_stat = (wa == OFF_IRQ_STAT);
    wire w_mask = (wa == OFF_IRQ_MASK);
    wire w_ro = (wa == OFF_STATUS) || (wa == OFF_LAST);
    wire w_hit = w_ctrl || w_stat || w_mask || w_ro;
    wire wr_lane0 = wr_fire && wstrb[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control: transmit enable, and a self-clearing send request
    logic [IRQ_W-1:0] irq_stat, irq_mask, next_stat;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_en <= CTRL_TX_EN_RST;
            send_pend <= 1'b0;
            irq_mask <= IRQ_MASK_RST;
        end else begin
            if (wr_lane0 && w_ctrl) tx_en <= wdata[CTRL_TX_EN];
            send_pend <= (wr_lane0 && w_ctrl && wdata[CTRL_SEND]) || (send_pend && !launch);
            if (wr_lane0 && w_mask) irq_mask <= wdata[IRQ_W-1:0];
        end
    end

    // sticky events: frame sent, request seen, word changed; set beats clear
    wire [IRQ_W-1:0] ev = {next_word != cur_word, req_hit && !req_seen, tx_done};
    wire [IRQ_W-1:0] w1c = (wr_lane0 && w_stat) ? wdata[IRQ_W-1:0] : '0;
    assign next_stat = (irq_stat & ~w1c) | ev;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat <= next_stat;
            irq <= |(next_stat & irq_mask);
        end
    end

    // read side, one outstanding read, data latched at address handshake
    wire [ADDR_W-1:0] ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire r_hit = (ra == OFF_CTRL) || (ra == OFF_STATUS) || (ra == OFF_LAST)
        || (ra == OFF_IRQ_STAT) || (ra == OFF_IRQ_MASK);
    wire [31:0] rd_mux = (ra == OFF_CTRL) ? {31'h0, tx_en} :
        (ra == OFF_STATUS) ? {23'h0, tx_busy, fsfwc_parity(cur_word), cur_word} :
        (ra == OFF_LAST) ? {24'h0, fsfwc_parity(last_word), last_word} :
        (ra == OFF_IRQ_STAT) ? {29'h0, irq_stat} :
        (ra == OFF_IRQ_MASK) ? {29'h0, irq_mask} : 32'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= r_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks on the encoder and the frame launcher
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_parity_odd;
        launch |-> ^launch_frame;
    endproperty
    a_parity_odd: assert property (p_parity_odd) else $error("even parity frame");

    property p_fields;
        (system_thermal && !low_side_driver_unready && ls_thermal_shutdown
            && !high_side_driver_unready && ls_overcurrent)
            |=> cur_word[2:0] == F1_SYS_THERM && cur_word[4:3] == F2_SHUT && cur_word[5];
    endproperty
    a_fields: assert property (p_fields) else $error("fields not combined");

    property p_powerup;
        $rose(tx_busy) && $past(powerup_pend, 2) |-> last_word == READY_WORD;
    endproperty
    a_powerup: assert property (p_powerup) else $error("power-up word not zero");

    property p_req_zero;
        launch && req_launch && !powerup_pend && cur_word == READY_WORD
            |-> launch_frame == {1'b1, READY_WORD};
    endproperty
    a_req_zero: assert property (p_req_zero) else $error("bad ready reply");

    property p_ov_code;
        bus_overvoltage && !system_thermal && !low_side_driver_unready
            |=> cur_word[2:0] == F1_OV;
    endproperty
    a_ov_code: assert property (p_ov_code) else $error("overvoltage code wrong");

    property p_uv55_code;
        bus_undervoltage && uv_level == 2'h3 && !bus_overvoltage && !system_thermal
            && !low_side_driver_unready |=> cur_word[2:0] == F1_UV55;
    endproperty
    a_uv55_code: assert property (p_uv55_code) else $error("uv 55 code wrong");

    property p_warn_code;
        ls_thermal_warn && !ls_thermal_shutdown && !high_side_driver_unready
            |=> cur_word[4:3] == F2_WARN;
    endproperty
    a_warn_code: assert property (p_warn_code) else $error("warning code wrong");

    property p_ls_unready;
        (trim_corrupt || sense_config_short) |=> cur_word[2:0] == F1_LS_UNREADY;
    endproperty
    a_ls_unready: assert property (p_ls_unready) else $error("ls unready missed");

    property p_hs_unready;
        (hs_link_loss || hs_rail_bad) |=> cur_word[4:3] == F2_HS_UNREADY;
    endproperty
    a_hs_unready: assert property (p_hs_unready) else $error("hs unready missed");

    property p_oc_flags;
        ##1 cur_word[6:5] == {$past(hs_overcurrent), $past(ls_overcurrent)};
    endproperty
    a_oc_flags: assert property (p_oc_flags) else $error("overcurrent flag wrong");

    property p_od_pin;
        fault_bus_oe |-> !fault_bus_o && tx_busy;
    endproperty
    a_od_pin: assert property (p_od_pin) else $error("pin driven while idle");

    property p_shut_code;
        ls_thermal_shutdown && !high_side_driver_unready
            |=> cur_word[4:3] == F2_SHUT;
    endproperty
    a_shut_code: assert property (p_shut_code) else $error("shutdown code wrong");

    property p_uv100_code;
        bus_undervoltage && uv_level == UV_100 && !bus_overvoltage
            && !system_thermal && !low_side_driver_unready
            |=> cur_word[2:0] == F1_UV100;
    endproperty
    a_uv100_code: assert property (p_uv100_code) else $error("uv 100 code wrong");

    property p_sys_code;
        system_thermal && !low_side_driver_unready |=> cur_word[2:0] == F1_SYS_THERM;
    endproperty
    a_sys_code: assert property (p_sys_code) else $error("thermal code wrong");

    c_powerup_frame: cover property (tx_done && last_word == READY_WORD);
    c_req_reply: cover property (launch && req_launch);
    c_multi_fault: cover property (tx_done && last_word[2:0] != F1_NONE && last_word[4:3] != F2_NONE);
    c_irq: cover property ($rose(irq));
    c_held_off: cover property (!tx_en && changed);
endmodule

//--- logic/fsfwc_pkg.sv
// shared constants, codes and helpers of the fault status word codec
package fsfwc_pkg;
    // clock and bus timing
    localparam int CLK_MHZ = 125;
    localparam int BIT_TIME_NS = 8000;
    localparam int BIT_CYC = (BIT_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int REQ_TIME_NS = 16000;
    localparam int REQ_CYC = (REQ_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int START_BITS = 1;
    localparam int STOP_BITS = 1;

    // word layout
    localparam int WORD_W = 7;
    localparam int FRAME_W = WORD_W + 1;
    localparam int FRAME_BITS = START_BITS + FRAME_W + STOP_BITS;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [WORD_W-1:0] READY_WORD = 7'h00;

    // field 1 held in word[2:0], word[0] is the first listed bit
    localparam logic [2:0] F1_NONE = 3'h0;
    localparam logic [2:0] F1_OV = 3'h4;
    localparam logic [2:0] F1_UV100 = 3'h2;
    localparam logic [2:0] F1_UV85 = 3'h6;
    localparam logic [2:0] F1_UV70 = 3'h1;
    localparam logic [2:0] F1_UV55 = 3'h5;
    localparam logic [2:0] F1_SYS_THERM = 3'h3;
    localparam logic [2:0] F1_LS_UNREADY = 3'h7;
    // field 2 held in word[4:3], word[3] is the first listed bit
    localparam logic [1:0] F2_NONE = 2'h0;
    localparam logic [1:0] F2_WARN = 2'h2;
    localparam logic [1:0] F2_SHUT = 2'h1;
    localparam logic [1:0] F2_HS_UNREADY = 2'h3;
    // undervoltage level select
    localparam logic [1:0] UV_100 = 2'h0;
    localparam logic [1:0] UV_85 = 2'h1;
    localparam logic [1:0] UV_70 = 2'h2;

    // register map, byte addresses
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_STATUS = 5'h04;
    localparam logic [4:0] OFF_LAST = 5'h08;
    localparam logic [4:0] OFF_IRQ_STAT = 5'h0c;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h10;
    localparam int CTRL_TX_EN = 0;
    localparam int CTRL_SEND = 1;
    localparam logic CTRL_TX_EN_RST = 1'b1;
    localparam int IRQ_W = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_START = 4'h2,
        TX_DATA = 4'h4,
        TX_STOP = 4'h8
    } fsfwc_tx_state_t;

    // odd parity over the seven status bits
    function automatic logic fsfwc_parity(input logic [WORD_W-1:0] w);
        return ~(^w);
    endfunction
endpackage

//--- logic/fsfwc_tx.sv
// open-drain frame sender: start bit, eight frame bits lsb first, stop bit
`timescale 1ns/1ps
module fsfwc_tx import fsfwc_pkg::*; #(
    parameter int BIT_CYCLES = BIT_CYC
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    input wire logic start, // one-cycle launch while idle
    input wire logic [FRAME_W-1:0] frame, // word and parity
    output logic busy, // frame on the line
    output logic bus_o, // line drive value, always low
    output logic bus_oe, // high while pulling the line low
    output logic done // one-cycle pulse after stop bit
);
    localparam logic [15:0] BIT_END = 16'(BIT_CYCLES - 1);

    fsfwc_tx_state_t state, next_state;
    logic [15:0] tick;
    logic [2:0] bit_idx;
    logic [FRAME_W-1:0] shreg;
    wire tick_end = (tick == BIT_END);
    wire next_bit = (state == TX_DATA && tick_end) ? shreg[1] : shreg[0];
    // a one bit releases the line, the pull-up makes it high
    wire next_oe = (next_state == TX_START) | ((next_state == TX_DATA) & ~next_bit);

    // frame sequencing
    always_comb begin
        next_state = state;
        case (state)
            TX_IDLE: if (start) next_state = TX_START;
            TX_START: if (tick_end) next_state = TX_DATA;
            TX_DATA: if (tick_end && bit_idx == LAST_BIT) next_state = TX_STOP;
            TX_STOP: if (tick_end) next_state = TX_IDLE;
            default: next_state = TX_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= TX_IDLE;
            tick <= 16'h0000;
        end else begin
            state <= next_state;
            tick <= (state == TX_IDLE || tick_end) ? 16'h0000 : tick + 16'h0001;
        end
    end

    // bit shifter, parity goes out right after bit 6
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bit_idx <= 3'h0;
            shreg <= '0;
        end else if (state == TX_IDLE && start) begin
            bit_idx <= 3'h0;
            shreg <= frame;
        end else if (state == TX_DATA && tick_end) begin
            bit_idx <= bit_idx + 3'h1;
            shreg <= {1'b0, shreg[FRAME_W-1:1]};
        end
    end

    // registered pin and status outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_oe <= 1'b0;
            bus_o <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            bus_oe <= next_oe;
            bus_o <= 1'b0;
            busy <= (next_state != TX_IDLE);
            done <= (state == TX_STOP && tick_end);
        end
    end

    // frame length helper for checking
    int frame_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn || done) frame_cnt <= 0;
        else if (busy) frame_cnt <= frame_cnt + 1;
    end

    property p_frame_len;
        @(posedge aclk) disable iff (!aresetn) done |-> frame_cnt == FRAME_BITS * BIT_CYCLES;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

    property p_never_high;
        @(posedge aclk) disable iff (!aresetn) (bus_o == 1'b0) && (busy || !bus_oe);
    endproperty
    a_never_high: assert property (p_never_high) else $error("line driven high or idle");

    property p_start_low;
        @(posedge aclk) disable iff (!aresetn) $rose(busy) |-> bus_oe [*4];
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit not low");
endmodule

//--- sim/fsfwc_mcu_model.sv
// behavioural system controller on the open-drain fault bus
`timescale 1ns/1ps
module fsfwc_mcu_model #(
    parameter int BIT_CYCLES = 4,
    parameter int REQ_LEN = 12
) (
    input wire logic aclk, // system clock
    input wire logic line, // resolved bus level
    input wire logic send_req, // pulse: hold the line low once
    output logic mcu_oe, // pulls the line low
    output logic [7:0] rx_frame, // last good word and parity
    output int rx_cnt, // frames received
    output int bad_cnt // frames dropped for even parity
);
    int t = 0;
    int rq = 0;
    logic rx_on = 0;
    logic [7:0] sh = 8'h00;
    // bridge kept off while polling: low-side inputs low, high-side inputs high
    logic low_side_drive_in_a = 1'b0, low_side_drive_in_b = 1'b0;
    logic high_side_drive_n_a = 1'b1, high_side_drive_n_b = 1'b1;
    initial begin
        mcu_oe = 1'b0;
        rx_frame = 8'h00;
        rx_cnt = 0;
        bad_cnt = 0;
    end
    // status request: only ever pulls low, the pull-up makes high
    always @(posedge aclk) begin
        if (rq > 0) begin
            rq = rq - 1;
            mcu_oe <= (rq != 0);
        end else if (send_req && line && !low_side_drive_in_a && !low_side_drive_in_b
            && high_side_drive_n_a && high_side_drive_n_b) begin
            rq = REQ_LEN;
            mcu_oe <= 1'b1;
        end
    end
    // mid-bit sampling; a word with bad parity is dropped, not kept
    always @(posedge aclk) begin
        if (!rx_on && !line && !mcu_oe) begin
            rx_on = 1'b1;
            t = 0;
        end else if (rx_on) begin
            t = t + 1;
            if (t % BIT_CYCLES == BIT_CYCLES / 2 && t > BIT_CYCLES && t < 9 * BIT_CYCLES)
                sh[t / BIT_CYCLES - 1] = line;
            if (t == 9 * BIT_CYCLES + BIT_CYCLES / 2) begin
                rx_on = 1'b0;
                if (^sh) rx_frame <= sh;
                else bad_cnt <= bad_cnt + 1;
                rx_cnt <= rx_cnt + 1;
            end
        end
    end
endmodule

//--- sim/testbench.sv
// self-checking bench of the fault status word codec
`timescale 1ns/1ps
module testbench import fsfwc_pkg::*;;
    localparam int BC = 4;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, send_req = 1'b0;
    logic [15:0] cond = 16'h0;
    wire logic awready, wready, bvalid, arready, rvalid, irq, dut_o, dut_oe, mcu_oe, line;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0] rx_frame;
    int rx_cnt, bad_cnt, c;
    int miscompares = 0;
    int checked = 0;
    logic [1:0] resp;
    logic [31:0] rd;
    // condition rows and the word each should give
    logic [15:0] rc [19] = '{16'h8000, 16'h4000, 16'h5000, 16'h6000, 16'h7000, 16'h0800,
        16'h0400, 16'h0200, 16'h0100, 16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0008,
        16'h0004, 16'h0002, 16'h0001, 16'h8083, 16'h0842};
    logic [6:0] rw [19] = '{7'h04, 7'h02, 7'h06, 7'h01, 7'h05, 7'h03, 7'h07, 7'h07, 7'h07,
        7'h10, 7'h08, 7'h18, 7'h18, 7'h18, 7'h18, 7'h20, 7'h40, 7'h74, 7'h2b};
    always #4 aclk = ~aclk;
    // open-drain line: high unless some end pulls low
    assign line = !(dut_oe || mcu_oe);
    fsfwc_top #(.BIT_CYCLES(BC), .REQ_CYCLES(8)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .bus_overvoltage(cond[15]), .bus_undervoltage(cond[14]), .uv_level(cond[13:12]),
        .system_thermal(cond[11]), .low_side_config_fault(cond[10]),
        .sense_config_short(cond[9]), .trim_corrupt(cond[8]), .ls_thermal_warn(cond[7]),
        .ls_thermal_shutdown(cond[6]), .hs_link_loss(cond[5]),
        .high_side_bypass_supply_bad(cond[4]), .hs_rail_bad(cond[3]),
        .high_side_config_fault(cond[2]), .ls_overcurrent(cond[1]),
        .hs_overcurrent(cond[0]), .fault_bus_i(line), .fault_bus_o(dut_o),
        .fault_bus_oe(dut_oe), .irq(irq));
    fsfwc_mcu_model #(.BIT_CYCLES(BC), .REQ_LEN(12)) i_mcu (.aclk(aclk), .line(line),
        .send_req(send_req), .mcu_oe(mcu_oe), .rx_frame(rx_frame), .rx_cnt(rx_cnt),
        .bad_cnt(bad_cnt));
    task automatic results();
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic fail(input string m);
        miscompares++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) fail(m);
    endtask
    // next received frame must carry w and its odd parity bit
    task automatic wait_frame(input logic [6:0] w);
        int c0, n;
        c0 = rx_cnt;
        for (n = 0; n < 300 && rx_cnt == c0; n++) @(posedge aclk);
        if (rx_cnt == c0) begin
            fail("no frame");
            results();
        end
        chk_val({24'h0, rx_frame}, {24'h0, ~^w, w}, "frame word");
        chk_val(32'(bad_cnt), 32'h0, "bad parity");
        chk_val({31'h0, dut_o}, 32'h0, "drive value");
    endtask
    task automatic axw(input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin
            fail("write hang");
            results();
        end
    endtask
    task automatic axr(input logic [4:0] a);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin
            fail("read hang");
            results();
        end
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        wait_frame(7'h00);
        axr(OFF_IRQ_MASK);
        chk_val(rd, 32'h0, "mask reset");
        // each condition alone, then two mixed rows, each followed by no fault
        for (int i = 0; i < 19; i++) begin
            cond <= rc[i];
            wait_frame(rw[i]);
            cond <= 16'h0;
            wait_frame(7'h00);
        end
        // status request with no fault present
        @(posedge aclk);
        send_req <= 1'b1;
        @(posedge aclk);
        send_req <= 1'b0;
        wait_frame(7'h00);
        // sender disabled: the change must wait
        axw(OFF_CTRL, 32'h0);
        c = rx_cnt;
        cond <= 16'h8000;
        repeat (80) @(posedge aclk);
        chk_val(32'(rx_cnt - c), 32'h0, "sent while disabled");
        axw(OFF_CTRL, 32'h1);
        wait_frame(7'h04);
        axr(OFF_STATUS);
        chk_val(rd & 32'hff, 32'h04, "status word");
        cond <= 16'h0;
        wait_frame(7'h00);
        // interrupt: clear, mask, raise by a forced send, clear again
        axw(OFF_IRQ_STAT, 32'h7);
        axw(OFF_IRQ_MASK, 32'h1);
        chk_val({31'h0, irq}, 32'h0, "irq after clear");
        axw(OFF_CTRL, 32'h3);
        wait_frame(7'h00);
        repeat (8) @(posedge aclk);
        chk_val({31'h0, irq}, 32'h1, "irq raise");
        axw(OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge aclk);
        chk_val({31'h0, irq}, 32'h0, "irq clear");
        // unmapped place
        axr(5'h14);
        chk_val({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped read resp");
        chk_val(rd, 32'h0, "unmapped read data");
        axw(5'h14, 32'h1);
        chk_val({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write resp");
        results();
    end
endmodule
